// file: hdl/dftm_pkg.sv
// package for the drive fault trip manager
package dftm_pkg;

	localparam int CLK_HZ = 10_000_000;
	localparam int RESET_LOCK_S = 10;
	localparam int OVIN_HOLD_S = 100;
	localparam int MPL_MIN_MS = 15;
	// cycle counts derived from the clock rate
	localparam longint RESET_LOCK_CYC = longint'(RESET_LOCK_S) * CLK_HZ;
	localparam longint OVIN_HOLD_CYC = longint'(OVIN_HOLD_S) * CLK_HZ;
	localparam longint MPL_MIN_CYC = (longint'(MPL_MIN_MS) * CLK_HZ + 999) / 1000;

	// thresholds in volts and millivolts, bus sample is whole volts
	localparam logic [9:0] UV_LO = 10'h0AF;
	localparam logic [9:0] UV_HI = 10'h159;
	localparam logic [9:0] OVIN_LO = 10'h186;
	localparam logic [9:0] OVIN_HI = 10'h30C;
	localparam logic [11:0] CS_LIMIT_MV = 12'h258;

	// numeric fault codes for the local display
	localparam logic [7:0] CODE_NONE = 8'h00;
	localparam logic [7:0] CODE_MEM = 8'h08;
	localparam logic [7:0] CODE_UV = 8'h09;
	localparam logic [7:0] CODE_CS = 8'h0A;
	localparam logic [7:0] CODE_CPU = 8'h0B;
	localparam logic [7:0] CODE_EXT = 8'h0C;
	localparam logic [7:0] CODE_LOCK = 8'h0D;
	localparam logic [7:0] CODE_GND = 8'h0E;
	localparam logic [7:0] CODE_OVIN = 8'h0F;
	localparam logic [7:0] CODE_MPL = 8'h10;
	localparam logic [7:0] CODE_FAN = 8'h14;
	localparam logic [7:0] CODE_OH = 8'h15;

	// text label index for the remote operator
	typedef enum logic [3:0] {
		DFTM_LBL_NONE,
		DFTM_LBL_MEM,
		DFTM_LBL_UV,
		DFTM_LBL_CS,
		DFTM_LBL_CPU,
		DFTM_LBL_EXT,
		DFTM_LBL_LOCK,
		DFTM_LBL_GND,
		DFTM_LBL_OVIN,
		DFTM_LBL_MPL,
		DFTM_LBL_FAN,
		DFTM_LBL_OH
	} dftm_label_t;

	typedef struct packed {
		logic [7:0] code;
		dftm_label_t label;
	} dftm_fault_t;

	typedef struct packed {
		logic high_class;
		logic ext_trip_en;
		logic run_lock_en;
		logic restart_en;
	} dftm_cfg_t;

	typedef struct packed {
		logic [9:0] bus_volts;
		logic [11:0] cs_mv;
		logic cpu_err;
		logic mem_err;
		logic ext_err;
		logic ground_fault;
		logic residual_v;
		logic overtemp;
		logic fan_low;
		logic power_lost;
	} dftm_sense_t;

	typedef enum logic [1:0] {
		DFTM_POWERON,
		DFTM_RUN,
		DFTM_TRIP,
		DFTM_PWRDOWN
	} dftm_state_t;

endpackage

// file: hdl/dftm_top.sv
// drive fault supervision, trip latch and fault display
`timescale 1ns/1ps
module dftm_top #(
	parameter longint LOCK_CYC = dftm_pkg::RESET_LOCK_CYC,
	parameter longint OVIN_CYC = dftm_pkg::OVIN_HOLD_CYC,
	parameter longint MPL_CYC = dftm_pkg::MPL_MIN_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire dftm_pkg::dftm_cfg_t cfg,
	input wire dftm_pkg::dftm_sense_t sense,
	input wire logic power_restored,
	input wire logic run_cmd,
	input wire logic motor_stopped,
	input wire logic reset_input_terminal,
	input wire logic stop_clear_key,
	output logic output_enable,
	output logic tripped,
	output logic restart_req,
	output logic reset_lock_busy,
	output dftm_pkg::dftm_fault_t fault
);

	////////////////////////////////////////////////////////////////////
	function automatic dftm_pkg::dftm_fault_t mk(input logic [7:0] c,
		input dftm_pkg::dftm_label_t l);
		dftm_pkg::dftm_fault_t f;
		f.code = c;
		f.label = l;
		return f;
	endfunction

	function automatic logic [9:0] pick(input logic hi, input logic [9:0] a,
		input logic [9:0] b);
		return hi ? b : a;
	endfunction

	////////////////////////////////////////////////////////////////////
	dftm_pkg::dftm_state_t state, next_state;
	dftm_pkg::dftm_fault_t next_fault;
	logic next_output_enable, next_tripped, next_restart_req, next_lock_busy;
	logic [31:0] lock_cnt, next_lock_cnt;
	logic [31:0] ovin_cnt, next_ovin_cnt;
	logic [31:0] loss_cnt, next_loss_cnt;
	logic mpl_pending, next_mpl_pending;
	logic no_reset, next_no_reset;

	logic rst_req;
	logic uv_hit, ovin_hit, reset_ok;
	dftm_pkg::dftm_fault_t cand;
	logic cand_hit;

	assign rst_req = reset_input_terminal | stop_clear_key;
	// bus falling past threshold is the undervoltage condition
	assign uv_hit = sense.bus_volts < pick(cfg.high_class, dftm_pkg::UV_LO,
		dftm_pkg::UV_HI);
	assign ovin_hit = sense.bus_volts > pick(cfg.high_class, dftm_pkg::OVIN_LO,
		dftm_pkg::OVIN_HI);
	assign reset_ok = rst_req && !no_reset && lock_cnt == 32'h0;

	////////////////////////////////////////////////////////////////////
	// running-time trip sources, fixed priority order
	always_comb begin
		cand_hit = 1'b1;
		cand = mk(dftm_pkg::CODE_NONE, dftm_pkg::DFTM_LBL_NONE);
		if (sense.mem_err) begin
			cand = mk(dftm_pkg::CODE_MEM, dftm_pkg::DFTM_LBL_MEM);
		end else if (sense.cpu_err) begin
			cand = mk(dftm_pkg::CODE_CPU, dftm_pkg::DFTM_LBL_CPU);
		end else if (uv_hit) begin
			cand = mk(dftm_pkg::CODE_UV, dftm_pkg::DFTM_LBL_UV);
		end else if (sense.overtemp && sense.fan_low) begin
			cand = mk(dftm_pkg::CODE_FAN, dftm_pkg::DFTM_LBL_FAN);
		end else if (sense.overtemp) begin
			cand = mk(dftm_pkg::CODE_OH, dftm_pkg::DFTM_LBL_OH);
		end else if (cfg.ext_trip_en && sense.ext_err) begin
			cand = mk(dftm_pkg::CODE_EXT, dftm_pkg::DFTM_LBL_EXT);
		end else if (motor_stopped && ovin_cnt >= 32'(OVIN_CYC)) begin
			cand = mk(dftm_pkg::CODE_OVIN, dftm_pkg::DFTM_LBL_OVIN);
		end else begin
			cand_hit = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	always_comb begin
		next_state = state;
		next_fault = fault;
		next_output_enable = output_enable;
		next_tripped = tripped;
		next_restart_req = 1'b0;
		next_lock_cnt = (lock_cnt != 32'h0) ? lock_cnt - 32'h1 : lock_cnt;
		next_lock_busy = next_lock_cnt != 32'h0;
		next_no_reset = no_reset;
		next_mpl_pending = mpl_pending;
		// continuous-while-stopped timer, cleared by any break
		if (motor_stopped && ovin_hit) begin
			next_ovin_cnt = (ovin_cnt < 32'(OVIN_CYC)) ? ovin_cnt + 32'h1 : ovin_cnt;
		end else begin
			next_ovin_cnt = 32'h0;
		end
		next_loss_cnt = 32'h0;
		case (state)
			dftm_pkg::DFTM_POWERON: begin
				// one-cycle power-on checks
				next_state = dftm_pkg::DFTM_TRIP;
				next_tripped = 1'b1;
				next_output_enable = 1'b0;
				next_lock_cnt = 32'(LOCK_CYC);
				next_lock_busy = 1'b1;
				if (sense.mem_err) begin
					next_fault = mk(dftm_pkg::CODE_MEM, dftm_pkg::DFTM_LBL_MEM);
					next_no_reset = 1'b1;
				end else if (sense.cs_mv >= dftm_pkg::CS_LIMIT_MV) begin
					next_fault = mk(dftm_pkg::CODE_CS, dftm_pkg::DFTM_LBL_CS);
				end else if (sense.ground_fault && !sense.residual_v) begin
					next_fault = mk(dftm_pkg::CODE_GND, dftm_pkg::DFTM_LBL_GND);
					next_no_reset = 1'b1;
				end else if (cfg.run_lock_en && run_cmd) begin
					next_fault = mk(dftm_pkg::CODE_LOCK, dftm_pkg::DFTM_LBL_LOCK);
				end else begin
					next_state = dftm_pkg::DFTM_RUN;
					next_tripped = 1'b0;
					next_output_enable = 1'b1;
					next_lock_cnt = 32'h0;
					next_lock_busy = 1'b0;
				end
			end
			dftm_pkg::DFTM_RUN: begin
				if (sense.power_lost) begin
					next_state = dftm_pkg::DFTM_PWRDOWN;
					next_output_enable = 1'b0;
					next_loss_cnt = 32'h1;
				end else if (cand_hit) begin
					next_state = dftm_pkg::DFTM_TRIP;
					next_fault = cand;
					next_tripped = 1'b1;
					next_output_enable = 1'b0;
					next_lock_cnt = 32'(LOCK_CYC);
					next_lock_busy = 1'b1;
					next_no_reset = sense.mem_err | sense.cpu_err;
				end
			end
			dftm_pkg::DFTM_PWRDOWN: begin
				next_loss_cnt = (loss_cnt < 32'(MPL_CYC)) ? loss_cnt + 32'h1 : loss_cnt;
				if (loss_cnt >= 32'(MPL_CYC)) begin
					next_mpl_pending = 1'b1;
				end
				if (power_restored) begin
					next_loss_cnt = 32'h0;
					next_mpl_pending = 1'b0;
					if (mpl_pending || loss_cnt >= 32'(MPL_CYC)) begin
						if (cfg.restart_en && run_cmd) begin
							next_state = dftm_pkg::DFTM_RUN;
							next_output_enable = 1'b1;
							next_restart_req = 1'b1;
						end else begin
							next_state = dftm_pkg::DFTM_TRIP;
							next_fault = mk(dftm_pkg::CODE_MPL, dftm_pkg::DFTM_LBL_MPL);
							next_tripped = 1'b1;
							next_lock_cnt = 32'(LOCK_CYC);
							next_lock_busy = 1'b1;
						end
					end else begin
						next_state = dftm_pkg::DFTM_RUN;
						next_output_enable = 1'b1;
					end
				end
			end
			dftm_pkg::DFTM_TRIP: begin
				if (reset_ok) begin
					next_state = dftm_pkg::DFTM_RUN;
					next_tripped = 1'b0;
					next_output_enable = 1'b1;
					next_fault = mk(dftm_pkg::CODE_NONE, dftm_pkg::DFTM_LBL_NONE);
				end
			end
			default: begin
				next_state = dftm_pkg::DFTM_POWERON;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// rst models power-on; a long loss ends in the supply dropping out
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= dftm_pkg::DFTM_POWERON;
			fault <= '0;
			output_enable <= 1'b0;
			tripped <= 1'b0;
			restart_req <= 1'b0;
			reset_lock_busy <= 1'b0;
			lock_cnt <= 32'h0;
			ovin_cnt <= 32'h0;
			loss_cnt <= 32'h0;
			mpl_pending <= 1'b0;
			no_reset <= 1'b0;
		end else if (ce) begin
			state <= next_state;
			fault <= next_fault;
			output_enable <= next_output_enable;
			tripped <= next_tripped;
			restart_req <= next_restart_req;
			reset_lock_busy <= next_lock_busy;
			lock_cnt <= next_lock_cnt;
			ovin_cnt <= next_ovin_cnt;
			loss_cnt <= next_loss_cnt;
			mpl_pending <= next_mpl_pending;
			no_reset <= next_no_reset;
		end
	end

endmodule

// file: testbench/dftm_top_assertions.sv
// concurrent checks on the fault trip manager ports
`timescale 1ns/1ps
module dftm_top_assertions (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire dftm_pkg::dftm_cfg_t cfg,
	input wire dftm_pkg::dftm_sense_t sense,
	input wire logic run_cmd,
	input wire logic output_enable,
	input wire logic tripped,
	input wire logic restart_req,
	input wire logic reset_lock_busy,
	input wire dftm_pkg::dftm_fault_t fault
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic calm;
	// running with no higher-priority cause present
	assign calm = ce && output_enable && !tripped && !sense.power_lost && !sense.mem_err;
	property p_latch; tripped |-> !output_enable; endproperty
	a_latch: assert property (p_latch) else $error("output on while tripped");
	property p_code; $rose(tripped) |-> fault.code != dftm_pkg::CODE_NONE && reset_lock_busy; endproperty
	a_code: assert property (p_code) else $error("trip without code or lockout");
	property p_lock; ce && tripped && reset_lock_busy |=> tripped; endproperty
	a_lock: assert property (p_lock) else $error("trip cleared during lockout");
	property p_noreset;
		ce && tripped && (fault.code == dftm_pkg::CODE_CPU || fault.code == dftm_pkg::CODE_GND
			|| fault.code == dftm_pkg::CODE_MEM) |=> tripped;
	endproperty
	a_noreset: assert property (p_noreset) else $error("power-cycle trip cleared");
	property p_cpu;
		calm && sense.cpu_err |=> tripped && fault.code == dftm_pkg::CODE_CPU
			&& fault.label == dftm_pkg::DFTM_LBL_CPU;
	endproperty
	a_cpu: assert property (p_cpu) else $error("processor error not tripped");
	property p_fan;
		calm && !sense.cpu_err && sense.overtemp && sense.fan_low
			&& sense.bus_volts >= (cfg.high_class ? dftm_pkg::UV_HI : dftm_pkg::UV_LO)
			|=> fault.code == dftm_pkg::CODE_FAN;
	endproperty
	a_fan: assert property (p_fan) else $error("fan overtemperature code wrong");
	property p_loss; ce && output_enable && sense.power_lost |=> !output_enable; endproperty
	a_loss: assert property (p_loss) else $error("output kept during power loss");
	property p_restart; restart_req |-> $past(run_cmd) && $past(cfg.restart_en); endproperty
	a_restart: assert property (p_restart) else $error("restart without mode and run");
endmodule
bind dftm_top dftm_top_assertions u_dftm_top_assertions (.*);

// file: testbench/dftm_plant.sv
// far-side model: power stage sensors and supply
`timescale 1ns/1ps
module dftm_plant (
	input wire dftm_pkg::dftm_sense_t want,
	output dftm_pkg::dftm_sense_t sense,
	output logic power_restored
);
	// supply reads back as soon as the loss ends
	assign sense = want;
	assign power_restored = !want.power_lost;
endmodule

// file: testbench/dftm_top_bench.sv
// self-checking bench for the fault trip manager
`timescale 1ns/1ps
module dftm_top_bench;
	typedef struct packed {
		logic po;
		dftm_pkg::dftm_sense_t s;
		dftm_pkg::dftm_cfg_t c;
		logic run;
		logic [7:0] code;
		dftm_pkg::dftm_label_t lbl;
	} dftm_row_t;
	localparam dftm_pkg::dftm_sense_t CLEAN = {10'h12C, 12'h000, 8'h00};
	logic clk = 0, rst = 1, run_cmd = 0, motor_stopped = 0, rit = 0, sck = 0;
	dftm_pkg::dftm_cfg_t cfg = 4'h0;
	dftm_pkg::dftm_sense_t want = CLEAN, sense;
	logic power_restored, output_enable, tripped, restart_req, reset_lock_busy;
	dftm_pkg::dftm_fault_t fault;
	int mismatches = 0, checked = 0, pulses;
	dftm_row_t rows [10];
	always #50 clk = ~clk;
	dftm_plant u_dftm_plant (.want(want), .sense(sense), .power_restored(power_restored));
	dftm_top #(.LOCK_CYC(20), .OVIN_CYC(30), .MPL_CYC(10)) u_dftm_top (.clk(clk), .rst(rst),
		.ce(1'b1), .cfg(cfg), .sense(sense), .power_restored(power_restored), .run_cmd(run_cmd),
		.motor_stopped(motor_stopped), .reset_input_terminal(rit), .stop_clear_key(sck),
		.output_enable(output_enable), .tripped(tripped), .restart_req(restart_req),
		.reset_lock_busy(reset_lock_busy), .fault(fault));
	task tick(input int n);
		repeat (n) @(posedge clk);
		#10;
	endtask
	task chk(input string name, input logic [11:0] exp, input logic [11:0] got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	task power_on(input dftm_pkg::dftm_sense_t s, input dftm_pkg::dftm_cfg_t c, input logic r);
		want = s;
		cfg = c;
		run_cmd = r;
		rst = 1;
		tick(1);
		rst = 0;
		tick(2);
	endtask
	task apply(input dftm_row_t r);
		power_on(r.po ? r.s : CLEAN, r.c, r.run);
		want = r.s;
		tick(2);
	endtask
	task report_and_stop;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		#200000;
		mismatches++;
		report_and_stop;
	end
	initial begin
		rows = '{{1'b1, 10'h12C, 12'h000, 8'h40, 4'h0, 1'b0, dftm_pkg::CODE_MEM, dftm_pkg::DFTM_LBL_MEM},
			{1'b1, 10'h12C, 12'h258, 8'h00, 4'h0, 1'b0, dftm_pkg::CODE_CS, dftm_pkg::DFTM_LBL_CS},
			{1'b1, 10'h12C, 12'h000, 8'h10, 4'h0, 1'b0, dftm_pkg::CODE_GND, dftm_pkg::DFTM_LBL_GND},
			{1'b1, 10'h12C, 12'h000, 8'h00, 4'h2, 1'b1, dftm_pkg::CODE_LOCK, dftm_pkg::DFTM_LBL_LOCK},
			{1'b0, 10'h12C, 12'h000, 8'h80, 4'h0, 1'b0, dftm_pkg::CODE_CPU, dftm_pkg::DFTM_LBL_CPU},
			{1'b0, 10'h0AE, 12'h000, 8'h00, 4'h0, 1'b0, dftm_pkg::CODE_UV, dftm_pkg::DFTM_LBL_UV},
			{1'b0, 10'h158, 12'h000, 8'h00, 4'h8, 1'b0, dftm_pkg::CODE_UV, dftm_pkg::DFTM_LBL_UV},
			{1'b0, 10'h12C, 12'h000, 8'h06, 4'h0, 1'b0, dftm_pkg::CODE_FAN, dftm_pkg::DFTM_LBL_FAN},
			{1'b0, 10'h12C, 12'h000, 8'h04, 4'h0, 1'b0, dftm_pkg::CODE_OH, dftm_pkg::DFTM_LBL_OH},
			{1'b0, 10'h12C, 12'h000, 8'h20, 4'h4, 1'b0, dftm_pkg::CODE_EXT, dftm_pkg::DFTM_LBL_EXT}};
		tick(6);
		for (int i = 0; i < 10; i++) begin
			apply(rows[i]);
			chk("code", 12'(rows[i].code), 12'(fault.code));
			chk("label", 12'(rows[i].lbl), 12'(fault.label));
			chk("output_enable", 12'h000, 12'(output_enable));
			chk("reset_lock_busy", 12'h001, 12'(reset_lock_busy));
		end
		// reset terminal held through lockout, then released by it
		power_on(CLEAN, 4'h0, 1'b0);
		want.bus_volts = 10'h064;
		tick(1);
		want = CLEAN;
		rit = 1;
		tick(17);
		chk("tripped in lockout", 12'h001, 12'(tripped));
		for (int i = 0; i < 40 && reset_lock_busy === 1'b1; i++) tick(1);
		tick(2);
		chk("tripped after reset", 12'h000, 12'(tripped));
		chk("output_enable after reset", 12'h001, 12'(output_enable));
		rit = 0;
		for (int i = 0; i < 5; i += 2) begin
			apply(rows[i]);
			rit = 1;
			sck = 1;
			tick(40);
			chk("power-cycle trip", 12'h001, 12'(tripped));
			rit = 0;
			sck = 0;
		end
		power_on(CLEAN, 4'h0, 1'b0);
		want.ext_err = 1;
		tick(5);
		chk("external disabled", 12'h000, 12'(tripped));
		power_on({10'h12C, 12'h000, 8'h18}, 4'h0, 1'b0);
		chk("residual skips test", 12'h001, 12'(output_enable));
		power_on(CLEAN, 4'h0, 1'b0);
		motor_stopped = 1;
		want.bus_volts = 10'h187;
		tick(25);
		chk("overvoltage early", 12'h000, 12'(tripped));
		tick(10);
		chk("overvoltage code", 12'(dftm_pkg::CODE_OVIN), 12'(fault.code));
		motor_stopped = 0;
		for (int m = 0; m < 3; m++) begin
			power_on(CLEAN, {3'h0, m == 1}, 1'b1);
			want.power_lost = 1;
			tick(m == 0 ? 5 : 15);
			want = CLEAN;
			pulses = 0;
			for (int i = 0; i < 4; i++) begin
				tick(1);
				pulses += restart_req === 1'b1;
			end
			chk("restart pulses", 12'(m == 1), 12'(pulses));
			chk("loss trip", 12'(m == 2), 12'(tripped));
			chk("loss code", m == 2 ? 12'(dftm_pkg::CODE_MPL) : 12'h000, 12'(fault.code));
		end
		power_on(CLEAN, 4'h0, 1'b0);
		want.power_lost = 1;
		tick(60);
		chk("long loss no trip", 12'h000, 12'(tripped));
		chk("long loss output", 12'h000, 12'(output_enable));
		// power cycle ends the long loss; outputs idle while held
		want = CLEAN;
		rst = 1;
		tick(1);
		chk("output_enable in reset", 12'h000, 12'(output_enable));
		chk("tripped in reset", 12'h000, 12'(tripped));
		chk("fault in reset", 12'h000, 12'(fault));
		chk("busy in reset", 12'h000, 12'(reset_lock_busy));
		rst = 0;
		tick(1);
		chk("output_enable after power-on", 12'h001, 12'(output_enable));
		chk("tripped after power-on", 12'h000, 12'(tripped));
		report_and_stop;
	end
endmodule
